/* core/divide_unit_pkg.sv */
// Constants, register map and carrier types of the integer divide unit.
// Assumes a 64-bit core issuing one divide at a time, registers on APB.
package divide_unit_pkg;

	// ************************************************************
	// Instruction fields (positions count from the image's least significant bit)
	// ************************************************************
	localparam logic [5:0] OPC_PRIMARY = 6'h1F;
	localparam logic [8:0] XO_DIV_DWORD_UNSIGNED = 9'h1C9;
	localparam logic [8:0] XO_DIV_WORD_SIGNED = 9'h1EB;
	localparam logic [8:0] XO_DIV_WORD_UNSIGNED = 9'h1CB;
	localparam int OPC_LSB = 26;
	localparam int XO_LSB = 1;
	localparam int OE_POS = 10;
	localparam int REC_POS = 0;

	// ************************************************************
	// Divider sizing
	// ************************************************************
	localparam logic [6:0] STEPS_DWORD = 7'h40;
	localparam logic [6:0] STEPS_WORD = 7'h20;

	// ************************************************************
	// Register offsets (byte addresses)
	// ************************************************************
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] EXC_OFS = 12'h004;
	localparam logic [11:0] COND_OFS = 12'h008;
	localparam logic [11:0] IRQ_STAT_OFS = 12'h00C;
	localparam logic [11:0] IRQ_MASK_OFS = 12'h010;
	localparam logic [11:0] RESULT_LO_OFS = 12'h014;
	localparam logic [11:0] RESULT_HI_OFS = 12'h018;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int CTRL_MODE64_POS = 0;
	localparam int CTRL_SUPPORT64_POS = 1;
	localparam int EXC_ERR_POS = 0;
	localparam int EXC_SUM_POS = 1;
	localparam int COND_SUM_POS = 0;
	localparam int COND_ZERO_POS = 1;
	localparam int COND_PLUS_POS = 2;
	localparam int COND_NEG_POS = 3;
	localparam int IRQ_DONE_POS = 0;
	localparam int IRQ_ERR_POS = 1;
	localparam int IRQ_ILL_POS = 2;
	localparam logic CTRL_MODE64_RST = 1'b1;
	localparam logic [1:0] EXC_RST = 2'h0;
	localparam logic [3:0] COND_RST = 4'h0;
	localparam logic [2:0] IRQ_MASK_RST = 3'h0;

	// ************************************************************
	// Carrier types
	// ************************************************************
	typedef struct packed {
		logic [31:0] instr;
		logic [63:0] src_a;
		logic [63:0] src_b;
	} div_req_t;

	typedef struct packed {
		logic [63:0] dest_reg;
		logic [3:0] cond_field_zero;
		logic illegal;
	} div_resp_t;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_DWORD_U,
		OP_WORD_S,
		OP_WORD_U
	} div_op_t;

endpackage : divide_unit_pkg

/* core/integer_divide_unit.sv */
// Integer divide execution unit: unsigned doubleword, signed and unsigned word divides.
// Assumes issue logic holds the request stable from start until done, and an APB master.
`timescale 1ns/1ns
`default_nettype none

module integer_divide_unit #(
	parameter bit SUPPORT_64 = 1'b1 // Implementation carries 64-bit instructions
) (
	input wire logic pclk, // Core clock, 50 MHz
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction, high for write
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic start, // One-cycle request strobe
	input wire divide_unit_pkg::div_req_t req, // Instruction and source operands
	output logic busy, // Divide in flight
	output logic done, // One-cycle result strobe
	output divide_unit_pkg::div_resp_t resp, // Quotient, condition field, illegal
	output logic irq // Level interrupt
);

	// ************************************************************
	// Elaboration checks
	// ************************************************************
	if (divide_unit_pkg::STEPS_WORD >= divide_unit_pkg::STEPS_DWORD) begin : g_bad_steps
		$error("word step count must be below doubleword step count");
	end

	// ************************************************************
	// Decode helpers
	// ************************************************************
	// Opcode class of an instruction image
	function automatic divide_unit_pkg::div_op_t decode_op(input logic [31:0] ins);
		logic [5:0] opc;
		logic [8:0] xo;
		opc = ins[divide_unit_pkg::OPC_LSB +: 6];
		xo = ins[divide_unit_pkg::XO_LSB +: 9];
		decode_op = divide_unit_pkg::OP_NONE;
		if (opc == divide_unit_pkg::OPC_PRIMARY) begin
			if (xo == divide_unit_pkg::XO_DIV_DWORD_UNSIGNED) begin
				decode_op = divide_unit_pkg::OP_DWORD_U;
			end else if (xo == divide_unit_pkg::XO_DIV_WORD_SIGNED) begin
				decode_op = divide_unit_pkg::OP_WORD_S;
			end else if (xo == divide_unit_pkg::XO_DIV_WORD_UNSIGNED) begin
				decode_op = divide_unit_pkg::OP_WORD_U;
			end
		end
	endfunction : decode_op

	// Absolute value of a 64-bit two's complement number
	function automatic logic [63:0] magnitude(input logic [63:0] v);
		magnitude = v[63] ? (~v + 64'h1) : v;
	endfunction : magnitude

	// ************************************************************
	// Register and state declarations
	// ************************************************************
	typedef enum {ST_IDLE, ST_RUN, ST_FIN} state_t;

	state_t state_r;
	divide_unit_pkg::div_op_t op_r;
	logic oe_r;
	logic rc_r;
	logic err_r;
	logic ill_r;
	logic neg_r;
	logic [6:0] cnt_r;
	logic [63:0] divisor_r;
	logic [63:0] quo_r;
	logic [63:0] rem_r;
	logic mode64_r;
	logic [1:0] exc_r;
	logic [3:0] cond_r;
	logic [2:0] irq_stat_r;
	logic [2:0] irq_mask_r;
	logic [63:0] last_r;

	divide_unit_pkg::div_op_t op_in;
	logic word_in;
	logic signed_in;
	logic [63:0] dvd_ext;
	logic [63:0] dvs_ext;
	logic zero_div;
	logic min_over_m1;
	logic ill_in;
	logic [64:0] rem_sh;
	logic [64:0] trial;
	logic [63:0] quo_fix;
	logic [63:0] dest_nxt;
	logic cmp_neg;
	logic cmp_zero;
	logic finish;
	logic upd_exc;
	logic upd_cr;
	logic so_after;
	logic wr_en;
	logic rd_hit;

	// ************************************************************
	// Operand preparation for the incoming request
	// ************************************************************
	// Extend word operands per signedness, flag the undefined cases
	always_comb begin
		op_in = decode_op(req.instr);
		word_in = (op_in == divide_unit_pkg::OP_WORD_S) || (op_in == divide_unit_pkg::OP_WORD_U);
		signed_in = (op_in == divide_unit_pkg::OP_WORD_S);
		if (op_in == divide_unit_pkg::OP_WORD_S) begin
			dvd_ext = {{32{req.src_a[31]}}, req.src_a[31:0]};
			dvs_ext = {{32{req.src_b[31]}}, req.src_b[31:0]};
		end else if (op_in == divide_unit_pkg::OP_WORD_U) begin
			dvd_ext = {32'h0, req.src_a[31:0]};
			dvs_ext = {32'h0, req.src_b[31:0]};
		end else begin
			dvd_ext = req.src_a;
			dvs_ext = req.src_b;
		end
		zero_div = (dvs_ext == 64'h0);
		min_over_m1 = signed_in && (req.src_a[31:0] == 32'h80000000)
			&& (req.src_b[31:0] == 32'hFFFFFFFF);
		ill_in = (op_in == divide_unit_pkg::OP_NONE)
			|| ((op_in == divide_unit_pkg::OP_DWORD_U) && !SUPPORT_64);
	end

	// ************************************************************
	// Restoring divide step
	// ************************************************************
	// One quotient bit per cycle on magnitudes
	always_comb begin
		rem_sh = {rem_r, quo_r[63]};
		trial = rem_sh - {1'b0, divisor_r};
	end

	// Sign fix-up and word placement of the finished quotient
	always_comb begin
		quo_fix = neg_r ? (~quo_r + 64'h1) : quo_r;
		if (err_r) begin
			dest_nxt = 64'h0;
		end else if (op_r == divide_unit_pkg::OP_WORD_U) begin
			dest_nxt = {32'h0, quo_fix[31:0]};
		end else begin
			dest_nxt = quo_fix;
		end
		if (op_r == divide_unit_pkg::OP_DWORD_U) begin
			cmp_neg = dest_nxt[63];
			cmp_zero = (dest_nxt == 64'h0);
		end else begin
			cmp_neg = dest_nxt[31];
			cmp_zero = (dest_nxt[31:0] == 32'h0);
		end
	end

	// ************************************************************
	// Sequencer
	// ************************************************************
	// Idle, iterate, then present the result for one cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (start) begin
						state_r <= (ill_in || zero_div || min_over_m1) ? ST_FIN : ST_RUN;
					end
				end
				ST_RUN: begin
					if (cnt_r == 7'h1) begin
						state_r <= ST_FIN;
					end
				end
				ST_FIN: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Capture of the request's attributes at start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_r <= divide_unit_pkg::OP_NONE;
			oe_r <= 1'b0;
			rc_r <= 1'b0;
			err_r <= 1'b0;
			ill_r <= 1'b0;
			neg_r <= 1'b0;
			divisor_r <= 64'h0;
		end else if (start && (state_r == ST_IDLE)) begin
			op_r <= op_in;
			oe_r <= req.instr[divide_unit_pkg::OE_POS];
			rc_r <= req.instr[divide_unit_pkg::REC_POS];
			err_r <= !ill_in && (zero_div || min_over_m1);
			ill_r <= ill_in;
			neg_r <= signed_in && (dvd_ext[63] ^ dvs_ext[63]);
			divisor_r <= signed_in ? magnitude(dvs_ext) : dvs_ext;
		end
	end

	// Partial remainder, quotient shift register and step count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quo_r <= 64'h0;
			rem_r <= 64'h0;
			cnt_r <= 7'h0;
		end else if (start && (state_r == ST_IDLE)) begin
			rem_r <= 64'h0;
			if (word_in) begin
				quo_r <= {(signed_in ? magnitude(dvd_ext) : dvd_ext) << 32};
				cnt_r <= divide_unit_pkg::STEPS_WORD;
			end else begin
				quo_r <= dvd_ext;
				cnt_r <= divide_unit_pkg::STEPS_DWORD;
			end
		end else if (state_r == ST_RUN) begin
			if (!trial[64]) begin
				rem_r <= trial[63:0];
				quo_r <= {quo_r[62:0], 1'b1};
			end else begin
				rem_r <= rem_sh[63:0];
				quo_r <= {quo_r[62:0], 1'b0};
			end
			cnt_r <= cnt_r - 7'h1;
		end
	end

	// ************************************************************
	// Result presentation
	// ************************************************************
	assign finish = (state_r == ST_FIN);
	assign upd_exc = finish && !ill_r && oe_r;
	assign upd_cr = finish && !ill_r && rc_r;
	assign so_after = exc_r[divide_unit_pkg::EXC_SUM_POS] | (upd_exc & err_r);
	assign busy = (state_r != ST_IDLE);

	// Registered answer to the issue logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done <= 1'b0;
			resp <= '0;
		end else begin
			done <= finish;
			if (finish) begin
				resp.dest_reg <= ill_r ? 64'h0 : dest_nxt;
				resp.cond_field_zero <= upd_cr ? {cmp_neg, !cmp_neg && !cmp_zero, cmp_zero, so_after}
					: cond_r;
				resp.illegal <= ill_r;
			end
		end
	end

	// ************************************************************
	// Software-visible state
	// ************************************************************
	assign wr_en = psel && penable && pwrite;

	// Mode control; support bit is read-only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode64_r <= divide_unit_pkg::CTRL_MODE64_RST;
		end else if (wr_en && (paddr == divide_unit_pkg::CTRL_OFS)) begin
			mode64_r <= pwdata[divide_unit_pkg::CTRL_MODE64_POS];
		end
	end

	// Exception flags: hardware update overrides a same-cycle write of the error bit; the summary bit takes the written value ORed with the error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exc_r <= divide_unit_pkg::EXC_RST;
		end else if (upd_exc) begin
			exc_r[divide_unit_pkg::EXC_ERR_POS] <= err_r;
			exc_r[divide_unit_pkg::EXC_SUM_POS] <= err_r
				| ((wr_en && (paddr == divide_unit_pkg::EXC_OFS))
				? pwdata[divide_unit_pkg::EXC_SUM_POS] : exc_r[divide_unit_pkg::EXC_SUM_POS]);
		end else if (wr_en && (paddr == divide_unit_pkg::EXC_OFS)) begin
			exc_r <= pwdata[1:0];
		end
	end

	// Condition field zero, recorded results win over software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cond_r <= divide_unit_pkg::COND_RST;
		end else if (upd_cr) begin
			cond_r[divide_unit_pkg::COND_NEG_POS] <= cmp_neg;
			cond_r[divide_unit_pkg::COND_PLUS_POS] <= !cmp_neg && !cmp_zero;
			cond_r[divide_unit_pkg::COND_ZERO_POS] <= cmp_zero;
			cond_r[divide_unit_pkg::COND_SUM_POS] <= so_after;
		end else if (wr_en && (paddr == divide_unit_pkg::COND_OFS)) begin
			cond_r <= pwdata[3:0];
		end
	end

	// Last quotient for software readback
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_r <= 64'h0;
		end else if (finish && !ill_r) begin
			last_r <= dest_nxt;
		end
	end

	// ************************************************************
	// Interrupts
	// ************************************************************
	// Sticky events, write one to clear, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= 3'h0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~((wr_en && (paddr == divide_unit_pkg::IRQ_STAT_OFS))
				? pwdata[2:0] : 3'h0))
				| {finish && ill_r, upd_exc && err_r, finish && !ill_r};
		end
	end

	// Interrupt mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_r <= divide_unit_pkg::IRQ_MASK_RST;
		end else if (wr_en && (paddr == divide_unit_pkg::IRQ_MASK_OFS)) begin
			irq_mask_r <= pwdata[2:0];
		end
	end

	assign irq = |(irq_stat_r & irq_mask_r);

	// ************************************************************
	// APB read path
	// ************************************************************
	// Zero-wait slave; unmapped addresses answer with an error
	always_comb begin
		rd_hit = 1'b1;
		prdata = 32'h0;
		unique case (paddr)
			divide_unit_pkg::CTRL_OFS: begin
				prdata[divide_unit_pkg::CTRL_MODE64_POS] = mode64_r;
				prdata[divide_unit_pkg::CTRL_SUPPORT64_POS] = SUPPORT_64;
			end
			divide_unit_pkg::EXC_OFS: prdata[1:0] = exc_r;
			divide_unit_pkg::COND_OFS: prdata[3:0] = cond_r;
			divide_unit_pkg::IRQ_STAT_OFS: prdata[2:0] = irq_stat_r;
			divide_unit_pkg::IRQ_MASK_OFS: prdata[2:0] = irq_mask_r;
			divide_unit_pkg::RESULT_LO_OFS: prdata = last_r[31:0];
			divide_unit_pkg::RESULT_HI_OFS: prdata = last_r[63:32];
			default: rd_hit = 1'b0;
		endcase
		if (!(psel && penable && !pwrite)) begin
			prdata = 32'h0;
		end
	end

	assign pready = 1'b1;
	assign pslverr = psel && penable && !rd_hit;

endmodule : integer_divide_unit

`default_nettype wire

/* verification/issue_model.sv */
// Issue-side partner: raises one start pulse per go and holds operands.
// Assumes the divide unit answers with a one-cycle done strobe.
`timescale 1ns/1ns
`default_nettype none

module issue_model (
	input wire logic pclk, // Core clock
	input wire logic presetn, // Reset, active low
	input wire logic go, // Bench request, one cycle
	input wire divide_unit_pkg::div_req_t cmd, // Request to issue
	input wire logic done, // Result strobe
	output logic start, // Request strobe
	output divide_unit_pkg::div_req_t req // Held request
);
	// One start pulse a cycle after go
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) start <= 1'b0;
		else start <= go;
	end
	// Hold until done, then scramble so stale operands never look valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) req <= '0;
		else if (go) req <= cmd;
		else if (done) req <= ~req;
	end
endmodule : issue_model
`default_nettype wire

/* verification/integer_divide_unit_chk.sv */
// Checker for the divide unit's request, result and register ports.
// Assumes it is bound to integer_divide_unit with the same SUPPORT_64.
`timescale 1ns/1ns
`default_nettype none

module integer_divide_unit_chk #(
	parameter bit SUPPORT_64 = 1'b1 // Mirrors the design
) (
	input wire logic pclk, // Core clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [31:0] prdata, // APB read data
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic start, // Request strobe
	input wire divide_unit_pkg::div_req_t req, // Request
	input wire logic busy, // In flight
	input wire logic done, // Result strobe
	input wire divide_unit_pkg::div_resp_t resp, // Result
	input wire logic irq // Interrupt
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	localparam logic [31:0] XMASK = 32'hFC0003FE;
	logic take, is_du, is_ws, is_wu, wexc;
	// Decode of accepted requests
	assign take = start && !busy;
	assign is_du = (req.instr & XMASK) == 32'h7C000392;
	assign is_ws = (req.instr & XMASK) == 32'h7C0003D6;
	assign is_wu = (req.instr & XMASK) == 32'h7C000396;
	assign wexc = req.src_b[31:0] == 32'h0
		|| (req.src_a[31:0] == 32'h80000000 && req.src_b[31:0] == 32'hFFFFFFFF);
	sequence s_du_go; take && is_du && SUPPORT_64 && req.src_b != 64'h0; endsequence
	sequence s_wu_go; take && is_wu && req.src_b[31:0] != 32'h0; endsequence
	sequence s_ws_go; take && is_ws && !wexc; endsequence
	sequence s_bad_go; take && ((is_du && !SUPPORT_64) || !(is_du || is_ws || is_wu)); endsequence
	a_du_quotient: assert property (s_du_go |-> ##66 (done &&
		resp.dest_reg == req.src_a / req.src_b)) else $error("dword quotient wrong or late");
	a_wu_quotient: assert property (s_wu_go |-> ##34 (done &&
		resp.dest_reg[31:0] == req.src_a[31:0] / req.src_b[31:0]))
		else $error("unsigned word quotient wrong or late");
	a_ws_quotient: assert property (s_ws_go |-> ##34 (done &&
		resp.dest_reg[31:0] == 32'($signed(req.src_a[31:0]) / $signed(req.src_b[31:0]))))
		else $error("signed word quotient wrong or late");
	a_zero_fast: assert property (take && is_du && req.src_b == 64'h0 |-> ##2 done)
		else $error("dword divide by zero not finished in two cycles");
	a_wexc_fast: assert property (take && is_ws && wexc |-> ##2 done)
		else $error("signed word exception not finished in two cycles");
	a_bad_illegal: assert property (s_bad_go |-> ##2 (done && resp.illegal))
		else $error("illegal request not reported");
	a_done_pulse: assert property (done |=> !done)
		else $error("done longer than one cycle");
	a_busy_follow: assert property (take |=> busy && !done)
		else $error("busy not raised after start");
	a_unmapped_err: assert property (psel && penable && paddr > 12'h018 |-> pslverr && prdata == 0)
		else $error("unmapped access not refused");
	a_ready_high: assert property (psel && penable |-> pready)
		else $error("access phase not answered at once");
endmodule : integer_divide_unit_chk

bind integer_divide_unit integer_divide_unit_chk #(.SUPPORT_64(SUPPORT_64)) chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .start(start),
	.req(req), .busy(busy), .done(done), .resp(resp), .irq(irq));
`default_nettype wire

/* verification/integer_divide_unit_test.sv */
// Self-checking bench for the divide unit: APB tasks plus issued divides.
// Assumes issue_model as the issue side and the bound checker.
`timescale 1ns/1ns
`default_nettype none

module integer_divide_unit_test;
	localparam logic [31:0] DU = 32'h7C000392;
	localparam logic [31:0] WS = 32'h7C0003D6;
	localparam logic [31:0] WU = 32'h7C000396;
	localparam logic [31:0] OVF = 32'h00000400;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, start, busy, done, irq, e;
	divide_unit_pkg::div_req_t cmd = '0, req;
	divide_unit_pkg::div_resp_t resp, n_resp;
	int fail_count = 0, compares = 0;
	// ************************************************************
	// Clock, design and issue side
	// ************************************************************
	always #10 pclk = ~pclk;
	integer_divide_unit uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .start(start), .req(req), .busy(busy), .done(done), .resp(resp),
		.irq(irq));
	issue_model model (.pclk(pclk), .presetn(presetn), .go(go), .cmd(cmd), .done(done),
		.start(start), .req(req));
	// Second unit without 64-bit support, sharing bus and request
	integer_divide_unit #(.SUPPORT_64(1'b0)) uut_narrow (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(), .pready(), .pslverr(), .start(start), .req(req), .busy(), .done(),
		.resp(n_resp), .irq());
	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// One APB transfer; read data and error land in q and e
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask : apb
	// Issue one divide and wait for its result
	task automatic div(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b);
		@(posedge pclk);
		cmd <= {ins, a, b};
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		repeat (100) begin
			@(posedge pclk);
			#1;
			if (done === 1'b1) break;
		end
		check("div done", done, 1'b1);
	endtask : div
	task automatic summarize;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	// ************************************************************
	// Watchdog and tests
	// ************************************************************
	initial begin
		repeat (5000) @(posedge pclk);
		fail_count++;
		summarize();
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, divide_unit_pkg::CTRL_OFS, 32'h0);
		check("ctrl reset", q, 32'h3);
		apb(1'b0, divide_unit_pkg::EXC_OFS, 32'h0);
		check("exc reset", q, 32'h0);
		div(DU | 32'h1, 64'hFFFFFFFFFFFFFFFF, 64'h3);
		check("du quotient", resp.dest_reg, 64'h5555555555555555);
		check("du cr pos", resp.cond_field_zero, 4'h4);
		check("narrow illegal", n_resp.illegal, 1'b1);
		div(DU, 64'hFFFFFFFFFFFFFFFF, 64'h1);
		check("du plain", resp.dest_reg, 64'hFFFFFFFFFFFFFFFF);
		div(DU | 32'h1, 64'h8000000000000007, 64'h1);
		check("du cr neg", resp.cond_field_zero, 4'h8);
		apb(1'b0, divide_unit_pkg::RESULT_LO_OFS, 32'h0);
		check("result lo", q, 32'h7);
		apb(1'b0, divide_unit_pkg::RESULT_HI_OFS, 32'h0);
		check("result hi", q, 32'h80000000);
		div(DU | 32'h1, 64'h5, 64'h7);
		check("du trunc", resp.dest_reg, 64'h0);
		check("du cr zero", resp.cond_field_zero, 4'h2);
		apb(1'b0, divide_unit_pkg::COND_OFS, 32'h0);
		check("cond reg", q, 32'h2);
		div(WS | 32'h1, 64'h12345678FFFFFFF9, 64'hABCD000000000002);
		check("ws neg a", resp.dest_reg[31:0], 32'hFFFFFFFD);
		check("ws cr", resp.cond_field_zero, 4'h8);
		div(WS, 64'h7, 64'h00000000FFFFFFFE);
		check("ws neg b", resp.dest_reg[31:0], 32'hFFFFFFFD);
		div(WU | 32'h1, 64'h12345678FFFFFFF9, 64'hABCD000000000002);
		check("wu quotient", resp.dest_reg[31:0], 32'h7FFFFFFC);
		check("wu cr", resp.cond_field_zero, 4'h4);
		div(DU | OVF | 32'h1, 64'h9, 64'h0);
		apb(1'b0, divide_unit_pkg::EXC_OFS, 32'h0);
		check("exc zero div", q, 32'h3);
		apb(1'b0, divide_unit_pkg::IRQ_STAT_OFS, 32'h0);
		check("stat err", q[1], 1'b1);
		check("irq masked", irq, 1'b0);
		apb(1'b1, divide_unit_pkg::IRQ_MASK_OFS, 32'h2);
		check("irq on", irq, 1'b1);
		apb(1'b1, divide_unit_pkg::IRQ_STAT_OFS, 32'h2);
		check("irq cleared", irq, 1'b0);
		div(WU | OVF, 64'hA, 64'h3);
		check("wu ovf q", resp.dest_reg[31:0], 32'h3);
		apb(1'b0, divide_unit_pkg::EXC_OFS, 32'h0);
		check("exc sticky", q, 32'h2);
		apb(1'b1, divide_unit_pkg::CTRL_OFS, 32'h0);
		apb(1'b0, divide_unit_pkg::CTRL_OFS, 32'h0);
		check("ctrl mode32", q, 32'h2);
		div(WS | OVF | 32'h1, 64'h80000000, 64'hFFFFFFFF);
		check("summary bit", resp.cond_field_zero[0], 1'b1);
		apb(1'b0, divide_unit_pkg::EXC_OFS, 32'h0);
		check("exc ws min", q, 32'h3);
		apb(1'b1, divide_unit_pkg::EXC_OFS, 32'h0);
		div(WU, 64'h5, 64'h0);
		apb(1'b0, divide_unit_pkg::EXC_OFS, 32'h0);
		check("exc no ovf", q, 32'h0);
		div(32'h0, 64'h5, 64'h1);
		check("illegal", resp.illegal, 1'b1);
		apb(1'b0, divide_unit_pkg::IRQ_STAT_OFS, 32'h0);
		check("stat all", q, 32'h7);
		apb(1'b0, 12'h020, 32'h0);
		check("unmapped err", e, 1'b1);
		check("unmapped data", q, 32'h0);
		summarize();
	end
endmodule : integer_divide_unit_test
`default_nettype wire
